/* File: verilog/ssg_pkg.sv */
// Constants and carrier types for the segment-shared general pin block
package ssg_pkg;

	// ****************************************
	// Special function register addresses
	// ****************************************
	localparam logic [7:0] SFR_PIN_GROUP0_DATA = 8'h80;
	localparam logic [7:0] SFR_PIN_GROUP1_DATA = 8'h90;
	localparam logic [7:0] SFR_PIN_GROUP1_DIRECTION = 8'h91;
	localparam logic [7:0] SFR_PIN_GROUP2_DATA = 8'ha0;
	localparam logic [7:0] SFR_PIN_GROUP2_DIRECTION = 8'ha1;
	localparam logic [7:0] SFR_PIN_GROUP0_DIRECTION = 8'ha2;
	localparam logic [7:0] SFR_PIN_GROUP3_DATA = 8'hb0;

	// ****************************************
	// I/O RAM layout
	// ****************************************
	localparam logic [7:0] IO_SEG_BASE = 8'h00; // Segment registers 44..75, one per address
	localparam logic [7:0] IO_SEG_FIRST = 8'h2c; // Segment number at IO_SEG_BASE
	localparam int IO_SEG_COUNT = 32;
	localparam logic [7:0] IO_MAP_BASE = 8'h60; // Map bytes 3..9 at base+3..base+9
	localparam logic [3:0] IO_MAP_LO = 4'h3;
	localparam logic [3:0] IO_MAP_HI = 4'h9;
	localparam logic [7:0] IO_RSEL_BASE = 8'h70; // Resource selectors, one per address
	localparam logic [7:0] IO_DED_DIR_BASE = 8'h80; // Dedicated pin direction 56..58
	localparam logic [7:0] IO_DED_VAL_BASE = 8'h84; // Dedicated pin value 56..58
	localparam logic [7:0] IO_OPT_CTRL = 8'h88; // Optical function select
	localparam int SEG_DATA_BIT = 0;
	localparam int SEG_DIR_BIT = 3;
	localparam int DED_DIR_BIT = 7;
	localparam int DED_VAL_BIT = 4;
	localparam int OPTICAL_RECEIVE_PIN_BIT = 0;
	localparam int OPTICAL_TRANSMIT_PIN_BIT = 1;

	// ****************************************
	// Pin layout
	// ****************************************
	localparam int NUM_PINS = 59; // Index 0 is the push-button input
	localparam int SEG_OFFSET = 20; // Segment number minus pin number
	localparam int FIRST_SEG_DIR_PIN = 24;
	localparam int FIRST_SEG_DATA_PIN = 31;
	localparam int FIRST_DED_PIN = 56;
	localparam int OPTICAL_RECEIVE_PIN_PIN = 1;
	localparam int OPTICAL_TRANSMIT_PIN_PIN = 2;
	localparam logic [58:0] PIN_EXISTS = 59'h7ff_fef0_7fff_ffff; // No pads 31..35 and 40
	localparam logic [58:0] PIN_LARGE_ONLY = 59'h0f0_44f0_1040_1000; // 12 22 28 36..39 42 46 52..55
	localparam logic [58:0] PIN_DEDICATED = 59'h700_0000_0000_0009; // Push-button, 3, 56..58

	// ****************************************
	// Resource selector codes
	// ****************************************
	localparam logic [2:0] RES_NONE = 3'h0;
	localparam logic [2:0] RES_RESERVED = 3'h1;
	localparam logic [2:0] RES_CNT0_CLK = 3'h2;
	localparam logic [2:0] RES_CNT1_CLK = 3'h3;
	localparam logic [2:0] RES_HI_RISE = 3'h4;
	localparam logic [2:0] RES_LO_RISE = 3'h5;
	localparam logic [2:0] RES_HI_FALL = 3'h6;
	localparam logic [2:0] RES_LO_FALL = 3'h7;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ssg_req_t;

	typedef struct packed {
		logic counter_zero_clock;
		logic counter_one_clock;
		logic high_priority_rise;
		logic low_priority_rise;
		logic high_priority_fall;
		logic low_priority_fall;
	} ssg_res_t;

endpackage

/* File: verilog/ssg_gpio_port.sv */
// Segment-shared general pin port: selection, direction, data and resource routing
`timescale 1ns/1ps

//Contract
// R1: After reset every general pin is an input until software sets direction.
// R2: Map bit 1 routes a shared pin to segment driver; 0 to general use.
// R3: In general use each pin's direction is set independently of others.
// R4: Direction bit cleared means input, set means output.
// R5: Port registers: write sets output latch, read returns pin state.
// R6: Port register zero: push-button at bit 0, pins 1..7 at bits 1..7.
// R7: Port register one: pins 8..15; pin 12 only on large package.
// R8: Port register two: pins 16..23; pin 22 only on large package.
// R9: Port register three: pins 24..30 at bits 0..6; pin 28 large only.
// R10: Direction registers zero, one, two control pins 1..7, 8..15, 16..23.
// R11: Pins 36..55: data through bit 0 of segment register.
// R12: Push-button, pin 3 and pins 56..58 are always general pins.
// R13: Pins 1 and 2 serve optical receive and transmit when selected.
// R14: Pins 24+ direction from segment bit 3; pins 56..58 own registers.
// R15: Three-bit selector routes a pin to a resource, even when output.
// R16: Several pins selecting one resource are combined by logical OR.
// R17: Map bit index of a shared pin equals its segment number.
// R18: Push-button has no direction control and is always an input.
module ssg_gpio_port #(
	parameter bit LARGE_PKG = 1'b1,
	parameter int NUM_RSEL = 12
) (
	input wire logic CLOCK, // Processor clock
	input wire logic RST_N, // Synchronous reset, active low
	input wire ssg_pkg::ssg_req_t SFR_REQ, // Special function register request
	output logic [7:0] SFR_RDATA, // Read data, one cycle after read
	input wire ssg_pkg::ssg_req_t IO_REQ, // I/O RAM request
	output logic [7:0] IO_RDATA, // Read data, one cycle after read
	input wire logic [58:0] PIN_IN, // Pad input levels
	output logic [58:0] PIN_OUT, // Pad output levels
	output logic [58:0] PIN_OE_N, // Pad output enables, low drives
	output logic [58:0] SEG_SELECT, // Pin handed to segment driver
	input wire logic OPTICAL_TRANSMIT_PIN_DATA, // Optical transmit data from UART
	output logic OPTICAL_RECEIVE_PIN_DATA, // Optical receive data to UART
	output ssg_pkg::ssg_res_t RES_OUT // Internal resource levels
);

	// ****************************************
	// Parameter checks
	// ****************************************
	if (NUM_RSEL < 1 || NUM_RSEL > 12) begin : g_bad_rsel
		$error("NUM_RSEL must lie between 1 and 12");
	end

	// ****************************************
	// State
	// ****************************************
	logic [7:0] port_q [4];
	logic [7:0] dir_q [3];
	logic [3:0] seg_q [ssg_pkg::IO_SEG_COUNT];
	logic [7:0] map_q [10];
	logic [2:0] rsel_q [NUM_RSEL];
	logic [2:0] ded_dir_q;
	logic [2:0] ded_val_q;
	logic optical_receive_pin_q;
	logic optical_transmit_pin_q;
	logic [58:0] s1_q, s2_q, s3_q, filt_q;
	logic [79:0] map_bits;
	logic [58:0] present_w, lcd_w, dir_w, dat_w, oe_n_d, out_d, pin_state;
	ssg_pkg::ssg_res_t res_d;

	// Flatten map bytes; bytes below 3 hold no shared pins
	always_comb begin
		map_bits = '0;
		for (int b = ssg_pkg::IO_MAP_LO; b <= ssg_pkg::IO_MAP_HI; b++) begin
			map_bits[b*8 +: 8] = map_q[b];
		end
	end

	// ****************************************
	// Per-pin selection of direction and data source
	// ****************************************
	for (genvar i = 0; i < ssg_pkg::NUM_PINS; i++) begin : g_pin
		assign present_w[i] = ssg_pkg::PIN_EXISTS[i] &
			(LARGE_PKG | ~ssg_pkg::PIN_LARGE_ONLY[i]);
		// Map bit index equals segment number; dedicated pins ignore the map
		if (ssg_pkg::PIN_DEDICATED[i] || i < 4) begin : g_ded
			assign lcd_w[i] = 1'b0; // R12
		end else begin : g_shared
			assign lcd_w[i] = map_bits[i + ssg_pkg::SEG_OFFSET]; // R2 R17
		end
		if (i == 0) begin : g_pb
			assign dir_w[i] = 1'b0; // R18
			assign dat_w[i] = 1'b0;
		end else if (i < ssg_pkg::FIRST_SEG_DIR_PIN) begin : g_sfr
			assign dir_w[i] = dir_q[i/8][i%8]; // R3 R10
			assign dat_w[i] = port_q[i/8][i%8]; // R5 R6 R7 R8
		end else if (i < ssg_pkg::FIRST_SEG_DATA_PIN) begin : g_p3
			assign dir_w[i] = seg_q[i-24][ssg_pkg::SEG_DIR_BIT]; // R14
			assign dat_w[i] = port_q[3][i-24]; // R9
		end else if (i < ssg_pkg::FIRST_DED_PIN) begin : g_seg
			assign dir_w[i] = seg_q[i-24][ssg_pkg::SEG_DIR_BIT]; // R14
			assign dat_w[i] = seg_q[i-24][ssg_pkg::SEG_DATA_BIT]; // R11
		end else begin : g_dedreg
			assign dir_w[i] = ded_dir_q[i-56]; // R14
			assign dat_w[i] = ded_val_q[i-56]; // R14
		end
		// Drive only present pins in general use set as outputs, plus pin 2 whenever optical transmit is selected
		if (i == ssg_pkg::OPTICAL_TRANSMIT_PIN_PIN) begin : g_tx
			assign oe_n_d[i] = ~(optical_transmit_pin_q | (present_w[i] & dir_w[i])); // R13
			assign out_d[i] = optical_transmit_pin_q ? OPTICAL_TRANSMIT_PIN_DATA : dat_w[i]; // R13
		end else if (i == ssg_pkg::OPTICAL_RECEIVE_PIN_PIN) begin : g_rx
			assign oe_n_d[i] = ~(~optical_receive_pin_q & present_w[i] & dir_w[i]); // R13
			assign out_d[i] = dat_w[i];
		end else begin : g_gen
			assign oe_n_d[i] = ~(present_w[i] & ~lcd_w[i] & dir_w[i]); // R4
			assign out_d[i] = dat_w[i];
		end
	end

	// Pin state seen by software; absent pins read zero
	assign pin_state = filt_q & present_w;

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Three stages; a level counts once the second and third agree
	always_ff @(posedge CLOCK) begin
		s1_q <= PIN_IN;
		s2_q <= s1_q;
		s3_q <= s2_q;
		filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
	end

	// ****************************************
	// Resource routing
	// ****************************************
	// Selectors track the pad level even when the pin drives it
	always_comb begin
		res_d = '0;
		for (int k = 0; k < NUM_RSEL; k++) begin
			case (rsel_q[k])
				ssg_pkg::RES_CNT0_CLK: res_d.counter_zero_clock |= filt_q[k]; // R15 R16
				ssg_pkg::RES_CNT1_CLK: res_d.counter_one_clock |= filt_q[k]; // R15 R16
				ssg_pkg::RES_HI_RISE: res_d.high_priority_rise |= filt_q[k]; // R15 R16
				ssg_pkg::RES_LO_RISE: res_d.low_priority_rise |= filt_q[k]; // R15 R16
				ssg_pkg::RES_HI_FALL: res_d.high_priority_fall |= filt_q[k]; // R15 R16
				ssg_pkg::RES_LO_FALL: res_d.low_priority_fall |= filt_q[k]; // R15 R16
				default: res_d = res_d; // None and reserved route nothing
			endcase
		end
	end

	// ****************************************
	// Special function register decode
	// ****************************************
	wire [7:0] sfr_a = SFR_REQ.addr;
	wire [7:0] sfr_rd_d =
		(sfr_a == ssg_pkg::SFR_PIN_GROUP0_DATA) ? pin_state[7:0] :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP1_DATA) ? pin_state[15:8] :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP2_DATA) ? pin_state[23:16] :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP3_DATA) ? {1'b0, pin_state[30:24]} :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP0_DIRECTION) ? dir_q[0] :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP1_DIRECTION) ? dir_q[1] :
		(sfr_a == ssg_pkg::SFR_PIN_GROUP2_DIRECTION) ? dir_q[2] : 8'h00;

	// ****************************************
	// I/O RAM decode
	// ****************************************
	wire [7:0] io_a = IO_REQ.addr;
	wire [7:0] seg_off = io_a - ssg_pkg::IO_SEG_BASE;
	wire [7:0] map_off = io_a - ssg_pkg::IO_MAP_BASE;
	wire [7:0] rsel_off = io_a - ssg_pkg::IO_RSEL_BASE;
	wire [7:0] ddir_off = io_a - ssg_pkg::IO_DED_DIR_BASE;
	wire [7:0] dval_off = io_a - ssg_pkg::IO_DED_VAL_BASE;
	wire hit_seg = seg_off < 8'(ssg_pkg::IO_SEG_COUNT);
	wire hit_map = map_off >= 8'(ssg_pkg::IO_MAP_LO) && map_off <= 8'(ssg_pkg::IO_MAP_HI);
	wire hit_rsel = rsel_off < 8'(NUM_RSEL);
	wire hit_ddir = ddir_off < 8'h03;
	wire hit_dval = dval_off < 8'h03;
	wire hit_opt = io_a == ssg_pkg::IO_OPT_CTRL;
	wire [4:0] seg_i = seg_off[4:0];
	wire [3:0] map_i = map_off[3:0];
	wire [3:0] rsel_i = rsel_off[3:0];
	wire [1:0] ddir_i = ddir_off[1:0];
	wire [1:0] dval_i = dval_off[1:0];
	wire [7:0] io_rd_d =
		hit_seg ? {4'h0, seg_q[seg_i]} :
		hit_map ? map_q[map_i] :
		hit_rsel ? {5'h00, rsel_q[rsel_i]} :
		hit_ddir ? 8'(ded_dir_q[ddir_i]) << ssg_pkg::DED_DIR_BIT :
		hit_dval ? 8'(ded_val_q[dval_i]) << ssg_pkg::DED_VAL_BIT :
		hit_opt ? {6'h00, optical_transmit_pin_q, optical_receive_pin_q} : 8'h00;

	// ****************************************
	// Register writes
	// ****************************************
	// Reset clears every direction bit so all pins come up as inputs
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			for (int g = 0; g < 4; g++) port_q[g] <= 8'h00;
			for (int g = 0; g < 3; g++) dir_q[g] <= 8'h00; // R1
			for (int g = 0; g < ssg_pkg::IO_SEG_COUNT; g++) seg_q[g] <= 4'h0; // R1
			for (int g = 0; g < 10; g++) map_q[g] <= 8'h00;
			for (int g = 0; g < NUM_RSEL; g++) rsel_q[g] <= ssg_pkg::RES_NONE;
			ded_dir_q <= 3'h0; // R1
			ded_val_q <= 3'h0;
			optical_receive_pin_q <= 1'b0;
			optical_transmit_pin_q <= 1'b0;
		end else begin
			if (SFR_REQ.we) begin
				case (sfr_a)
					ssg_pkg::SFR_PIN_GROUP0_DATA: port_q[0] <= SFR_REQ.wdata; // R5
					ssg_pkg::SFR_PIN_GROUP1_DATA: port_q[1] <= SFR_REQ.wdata; // R5
					ssg_pkg::SFR_PIN_GROUP2_DATA: port_q[2] <= SFR_REQ.wdata; // R5
					ssg_pkg::SFR_PIN_GROUP3_DATA: port_q[3] <= {1'b0, SFR_REQ.wdata[6:0]}; // R9
					ssg_pkg::SFR_PIN_GROUP0_DIRECTION: dir_q[0] <= {SFR_REQ.wdata[7:1], 1'b0}; // R18
					ssg_pkg::SFR_PIN_GROUP1_DIRECTION: dir_q[1] <= SFR_REQ.wdata; // R10
					ssg_pkg::SFR_PIN_GROUP2_DIRECTION: dir_q[2] <= SFR_REQ.wdata; // R10
					default: port_q[0] <= port_q[0]; // Unmapped writes are dropped
				endcase
			end
			if (IO_REQ.we) begin
				if (hit_seg) seg_q[seg_i] <= IO_REQ.wdata[3:0];
				if (hit_map) map_q[map_i] <= IO_REQ.wdata;
				if (hit_rsel) rsel_q[rsel_i] <= IO_REQ.wdata[2:0];
				if (hit_ddir) ded_dir_q[ddir_i] <= IO_REQ.wdata[ssg_pkg::DED_DIR_BIT];
				if (hit_dval) ded_val_q[dval_i] <= IO_REQ.wdata[ssg_pkg::DED_VAL_BIT];
				if (hit_opt) begin
					optical_receive_pin_q <= IO_REQ.wdata[ssg_pkg::OPTICAL_RECEIVE_PIN_BIT];
					optical_transmit_pin_q <= IO_REQ.wdata[ssg_pkg::OPTICAL_TRANSMIT_PIN_BIT];
				end
			end
		end
	end

	// ****************************************
	// Output flops
	// ****************************************
	// Pads released and read data cleared during reset
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			PIN_OUT <= '0;
			PIN_OE_N <= '1; // R1
			SEG_SELECT <= '0;
			SFR_RDATA <= 8'h00;
			IO_RDATA <= 8'h00;
			OPTICAL_RECEIVE_PIN_DATA <= 1'b1;
			RES_OUT <= '0;
		end else begin
			PIN_OUT <= out_d;
			PIN_OE_N <= oe_n_d;
			SEG_SELECT <= lcd_w & present_w; // R2
			SFR_RDATA <= SFR_REQ.re ? sfr_rd_d : 8'h00; // R5
			IO_RDATA <= IO_REQ.re ? io_rd_d : 8'h00;
			OPTICAL_RECEIVE_PIN_DATA <= optical_receive_pin_q ? filt_q[ssg_pkg::OPTICAL_RECEIVE_PIN_PIN] : 1'b1; // R13
			RES_OUT <= res_d;
		end
	end

endmodule

/* File: testbench/ssg_gpio_port_assertions.sv */
// Port checker for the segment-shared general pin block
`timescale 1ns/1ps
module ssg_gpio_port_assertions #(
	parameter bit LARGE_PKG = 1'b1,
	parameter int NUM_RSEL = 12
) (
	input wire logic CLOCK, // Clock
	input wire logic RST_N, // Reset
	input wire ssg_pkg::ssg_req_t SFR_REQ, // SPECIAL_FUNCTION_REGISTER request
	input wire logic [7:0] SFR_RDATA, // SPECIAL_FUNCTION_REGISTER read data
	input wire ssg_pkg::ssg_req_t IO_REQ, // I/O request
	input wire logic [7:0] IO_RDATA, // I/O read data
	input wire logic [58:0] PIN_IN, // Pad levels
	input wire logic [58:0] PIN_OUT, // Pad outputs
	input wire logic [58:0] PIN_OE_N, // Pad enables
	input wire logic [58:0] SEG_SELECT, // Segment hand-over
	input wire logic OPTICAL_TRANSMIT_PIN_DATA, // Optical transmit
	input wire logic OPTICAL_RECEIVE_PIN_DATA, // Optical receive
	input wire ssg_pkg::ssg_res_t RES_OUT // Resource levels
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// ****************************************
	// Properties
	// ****************************************
	property p_reset_inputs; $rose(RST_N) |-> PIN_OE_N == '1; endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pad driven after reset");
	property p_sfr_idle; !$past(SFR_REQ.re) |-> SFR_RDATA == 8'h00; endproperty
	a_sfr_idle: assert property (p_sfr_idle) else $error("SPECIAL_FUNCTION_REGISTER data without read");
	property p_io_idle; !$past(IO_REQ.re) |-> IO_RDATA == 8'h00; endproperty
	a_io_idle: assert property (p_io_idle) else $error("I/O data without read");
	property p_pb_input; PIN_OE_N[0] && !SEG_SELECT[0]; endproperty
	a_pb_input: assert property (p_pb_input) else $error("push-button not input");
	property p_dedicated; SEG_SELECT[58:56] == 3'h0 && !SEG_SELECT[3]; endproperty
	a_dedicated: assert property (p_dedicated) else $error("dedicated pin to segment");
	property p_seg_release; (SEG_SELECT & ~PIN_OE_N) == '0; endproperty
	a_seg_release: assert property (p_seg_release) else $error("segment pin driven");
	property p_dir1_write;
		SFR_REQ.we && SFR_REQ.addr == ssg_pkg::SFR_PIN_GROUP1_DIRECTION |-> ##2
		(~PIN_OE_N[15:8] == ($past(SFR_REQ.wdata, 2) & ~SEG_SELECT[15:8]));
	endproperty
	a_dir1_write: assert property (p_dir1_write) else $error("group one direction");
	property p_port1_out;
		SFR_REQ.we && SFR_REQ.addr == ssg_pkg::SFR_PIN_GROUP1_DATA |-> ##2
		((PIN_OUT[15:8] & ~PIN_OE_N[15:8]) == ($past(SFR_REQ.wdata, 2) & ~PIN_OE_N[15:8]));
	endproperty
	a_port1_out: assert property (p_port1_out) else $error("group one output");
	property p_seg_cause; $changed(SEG_SELECT) |-> $past(IO_REQ.we, 2); endproperty
	a_seg_cause: assert property (p_seg_cause) else $error("map change unasked");
	property p_oe_cause;
		$changed(PIN_OE_N) |-> $past(SFR_REQ.we, 2) || $past(IO_REQ.we, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("direction change unasked");
endmodule

bind ssg_gpio_port ssg_gpio_port_assertions #(.LARGE_PKG(LARGE_PKG), .NUM_RSEL(NUM_RSEL)) chk_u (
	.CLOCK(CLOCK), .RST_N(RST_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
	.IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
	.PIN_OE_N(PIN_OE_N), .SEG_SELECT(SEG_SELECT), .OPTICAL_TRANSMIT_PIN_DATA(OPTICAL_TRANSMIT_PIN_DATA),
	.OPTICAL_RECEIVE_PIN_DATA(OPTICAL_RECEIVE_PIN_DATA), .RES_OUT(RES_OUT));

/* File: testbench/ssg_board_model.sv */
// Board model closing the pads of the general pin block
`timescale 1ns/1ps
module ssg_board_model (
	input wire logic [58:0] pin_out, // Device output levels
	input wire logic [58:0] pin_oe_n, // Device enables, low drives
	input wire logic [58:0] ext_level, // Levels the board applies
	output logic [58:0] pin_in // Resolved pad levels
);
	// Driven pads show the device level, released pads the board level
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

/* File: testbench/ssg_gpio_port_tb_top.sv */
// Self-checking bench for the segment-shared general pin block
`timescale 1ns/1ps
module ssg_gpio_port_tb_top;
	localparam logic [7:0] PG0 = ssg_pkg::SFR_PIN_GROUP0_DATA;
	localparam logic [7:0] PG1 = ssg_pkg::SFR_PIN_GROUP1_DATA;
	localparam logic [7:0] D0 = ssg_pkg::SFR_PIN_GROUP0_DIRECTION;
	localparam logic [7:0] D1 = ssg_pkg::SFR_PIN_GROUP1_DIRECTION;
	localparam logic [58:0] PAT = {28'h0, 31'h5a3c_c3a5};
	logic clock;
	logic rst_n;
	ssg_pkg::ssg_req_t sfr_req;
	ssg_pkg::ssg_req_t io_req;
	logic [7:0] sfr_rdata;
	logic [7:0] io_rdata;
	logic [58:0] pin_in;
	logic [58:0] pin_out;
	logic [58:0] pin_oe_n;
	logic [58:0] seg_select;
	logic [58:0] ext_level;
	logic optical_transmit_pin_data;
	logic optical_receive_pin_data;
	ssg_pkg::ssg_res_t res_out;
	logic [7:0] q;
	int n_mismatch = 0;
	int n_checks = 0;
	// ****************************************
	// Design, board and clock
	// ****************************************
	ssg_gpio_port #(.LARGE_PKG(1'b1), .NUM_RSEL(12)) dut_u (.CLOCK(clock), .RST_N(rst_n),
		.SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata), .IO_REQ(io_req), .IO_RDATA(io_rdata),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .SEG_SELECT(seg_select),
		.OPTICAL_TRANSMIT_PIN_DATA(optical_transmit_pin_data), .OPTICAL_RECEIVE_PIN_DATA(optical_receive_pin_data), .RES_OUT(res_out));
	ssg_board_model board_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
		.pin_in(pin_in));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// One byte access; read data is taken in the cycle after the read edge
	task automatic acc(input bit io, input bit rd, input logic [7:0] a, input logic [7:0] d);
		ssg_pkg::ssg_req_t r;
		r = '{we: !rd, re: rd, addr: a, wdata: d};
		tick(1);
		if (io)
			io_req = r;
		else
			sfr_req = r;
		tick(1);
		io_req = '0;
		sfr_req = '0;
		q = io ? io_rdata : sfr_rdata;
	endtask
	task automatic wr(input bit io, input logic [7:0] a, input logic [7:0] d);
		acc(io, 1'b0, a, d);
	endtask
	task automatic rd(input bit io, input logic [7:0] a, input logic [7:0] exp);
		acc(io, 1'b1, a, 8'h00);
		check(q, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		sfr_req = '0;
		io_req = '0;
		ext_level = '0;
		optical_transmit_pin_data = 1'b0;
		tick(6);
		rst_n = 1'b1;
		check(&pin_oe_n, 1'b1);
		rd(0, D0, 8'h00);
		rd(0, D1, 8'h00);
		rd(0, ssg_pkg::SFR_PIN_GROUP2_DIRECTION, 8'h00);
		// Pad levels seen through the four port registers
		for (int k = 0; k < 2; k++) begin
			ext_level = k ? ~PAT : PAT;
			tick(8);
			rd(0, PG0, ext_level[7:0]);
			rd(0, PG1, ext_level[15:8]);
			rd(0, ssg_pkg::SFR_PIN_GROUP2_DATA, ext_level[23:16]);
			rd(0, ssg_pkg::SFR_PIN_GROUP3_DATA, {1'b0, ext_level[30:24]});
		end
		rd(0, 8'h81, 8'h00);
		// Output latch and direction
		wr(0, PG1, 8'ha5);
		wr(0, D1, 8'hff);
		tick(1);
		check(pin_oe_n[15:8], 8'h00);
		check(pin_out[15:8], 8'ha5);
		tick(6);
		rd(0, PG1, 8'ha5);
		// Latch rewrite while the group already drives
		wr(0, PG1, 8'h3c);
		tick(1);
		check(pin_out[15:8], 8'h3c);
		wr(0, D0, 8'h13);
		rd(0, D0, 8'h12);
		check(pin_oe_n[7:0], 8'hed);
		// Pin 4 handed to its segment through map bit 24 and back
		wr(1, 8'h63, 8'h01);
		tick(1);
		check({seg_select[4], pin_oe_n[4]}, 2'b11);
		wr(1, 8'h63, 8'h00);
		tick(1);
		check({seg_select[4], pin_oe_n[4]}, 2'b00);
		// Segment register pins 24 and 43, dedicated pin 56
		wr(1, 8'h13, 8'h09);
		wr(1, 8'h00, 8'h08);
		wr(1, 8'h80, 8'h80);
		wr(1, 8'h84, 8'h10);
		tick(1);
		check({pin_oe_n[56], pin_oe_n[43], pin_oe_n[24]}, 3'b000);
		check({pin_out[56], pin_out[43]}, 2'b11);
		tick(6);
		acc(1, 1'b1, 8'h13, 8'h00);
		check(q[0], 1'b1);
		// Pins 4 and 5 share every resource code; pin 5 output high, pin 4 low
		wr(0, PG0, 8'h20);
		wr(0, D0, 8'h32);
		for (int c = 0; c < 8; c++) begin
			wr(1, 8'h74, c[7:0]);
			wr(1, 8'h75, c[7:0]);
			tick(8);
			check(res_out, c < 2 ? 6'h00 : 6'h20 >> (c - 2));
		end
		// Optical function on pins 1 and 2
		wr(0, D0, 8'h00);
		optical_transmit_pin_data = 1'b1;
		ext_level[1] = 1'b0;
		wr(1, 8'h88, 8'h03);
		tick(8);
		check({pin_out[2], pin_oe_n[2], optical_receive_pin_data}, 3'b100);
		wr(1, 8'h88, 8'h00);
		tick(8);
		check(optical_receive_pin_data, 1'b1);
		// Second reset in mid-run
		rst_n = 1'b0;
		tick(6);
		rst_n = 1'b1;
		check(&pin_oe_n, 1'b1);
		rd(0, D1, 8'h00);
		tally_and_finish();
	end
endmodule
